// file: hw/alarm_history_map.vh
`ifndef ALARM_HISTORY_MAP_VH
`define ALARM_HISTORY_MAP_VH

// clock and time base
`define AHR_CLK_PERIOD_NS 10
`define AHR_NS_PER_MS     1000000
`define AHR_TICK_MS       100
`define AHR_HOLD_MS       1000
`define AHR_HOUR_S        3600
`define AHR_MS_PER_S      1000

// history geometry
`define AHR_DEPTH         10
`define AHR_IDX_W         4
`define AHR_CODE_W        12
`define AHR_BIN_W         32
`define AHR_DIGITS        10
`define AHR_GROUP_W       16

// stamp digit groups inside the decimal stamp
`define AHR_LOW_LSB       0
`define AHR_MID_LSB       16
`define AHR_HIGH_LSB      32
`define AHR_HIGH_W        8

// view fields, in the order a short shift press walks them
`define AHR_FLD_CODE      2'h0
`define AHR_FLD_LOW       2'h1
`define AHR_FLD_MID       2'h2
`define AHR_FLD_HIGH      2'h3

// decimal digit limits
`define AHR_BCD_NINE      4'h9
`define AHR_BCD_ZERO      4'h0

`endif

// file: hw/alarm_history_recorder.v
// What this block does
// - keep ten newest alarms with code and stamp
// - count powered time in 100 ms, stamp alarms
// - stamp counter lasts beyond 13 years
// - same alarm within one hour is dropped
// - history survives alarm reset, power loss
// - long shift in history view shows newest
// - down steps older, up newer, index shown
// - short shift cycles code, low, mid, high
// - empty slot shows index with dashes
// - long shift while viewing returns to menu
// - viewing allowed in any drive state
`timescale 1ns/100ps
`default_nettype none
`include "alarm_history_map.vh"
module alarm_history_recorder #(
  parameter TICK_CYCLES =
    `AHR_TICK_MS * `AHR_NS_PER_MS / `AHR_CLK_PERIOD_NS,
  parameter HOLD_CYCLES =
    `AHR_HOLD_MS * `AHR_NS_PER_MS / `AHR_CLK_PERIOD_NS,
  parameter DEPTH       = `AHR_DEPTH,
  parameter CODE_W      = `AHR_CODE_W
) (
  // clock and reset
  input  wire                       clk_sys_in,
  input  wire                       srst_in,
  // supply status pins
  input  wire                       ctrl_power_on_in,
  input  wire                       main_power_on_in,
  // alarm source, same clock
  input  wire                       alarm_event_in,
  input  wire [CODE_W-1:0]          alarm_code_in,
  input  wire                       history_clear_function_in,
  // keypad pins
  input  wire                       key_up_in,
  input  wire                       key_down_in,
  input  wire                       key_shift_in,
  // menu, same clock
  input  wire                       alarm_history_view_in,
  // display
  output reg                        disp_active_out,
  output reg  [`AHR_IDX_W-1:0]      disp_index_out,
  output reg  [1:0]                 disp_field_out,
  output reg                        disp_empty_out,
  output reg  [`AHR_GROUP_W-1:0]    disp_digits_out,
  output reg                        exit_to_menu_out,
  // history status
  output reg                        record_out,
  output reg                        discard_out,
  output reg  [`AHR_IDX_W-1:0]      history_count_out
);

  localparam STATE_IDLE = 1'b0;
  localparam STATE_VIEW = 1'b1;

  localparam BIN_W  = `AHR_BIN_W;
  localparam BCD_W  = 4 * `AHR_DIGITS;
  localparam [BIN_W-1:0] HOUR_UNITS =
    `AHR_HOUR_S * `AHR_MS_PER_S / `AHR_TICK_MS;
  localparam [31:0]           LAST_FULL = DEPTH - 1;
  localparam [`AHR_IDX_W-1:0] IDX_LAST  = LAST_FULL[`AHR_IDX_W-1:0];
  localparam [`AHR_IDX_W-1:0] IDX_ONE   = {{(`AHR_IDX_W-1){1'b0}}, 1'b1};

  // running total
  wire [BIN_W-1:0] now_bin;
  wire [BCD_W-1:0] now_bcd;

  // key events
  wire up_press;
  wire down_press;
  wire shift_short;
  wire shift_long;

  // history store; slot 0 is the newest entry
  reg  [CODE_W-1:0] code_ff [0:DEPTH-1];
  reg  [BCD_W-1:0]  bcd_ff  [0:DEPTH-1];
  reg  [BIN_W-1:0]  bin_ff  [0:DEPTH-1];
  reg  [DEPTH-1:0]  valid_ff;

  // view state
  reg                  state_ff;
  reg  [`AHR_IDX_W-1:0] index_ff;
  reg  [1:0]           field_ff;

  // repeat search
  reg              hit;
  reg  [BIN_W-1:0] hit_bin;
  reg  [BIN_W-1:0] elapsed;
  wire             accept;
  wire             do_record;
  wire [DEPTH-1:0] nxt_valid;

  // display selection
  reg  [`AHR_GROUP_W-1:0] nxt_digits;
  reg  [CODE_W-1:0]       sel_code;
  reg  [BCD_W-1:0]        sel_bcd;
  reg                     sel_valid;
  reg  [`AHR_IDX_W-1:0]   nxt_count;

  integer i;
  integer j;

  operating_time_counter #(
    .TICK_CYCLES (TICK_CYCLES),
    .DIGITS      (`AHR_DIGITS),
    .BIN_W       (BIN_W)
  ) u_time (
    .clk_sys_in       (clk_sys_in),
    .srst_in          (srst_in),
    .ctrl_power_on_in (ctrl_power_on_in),
    .main_power_on_in (main_power_on_in),
    .bin_out          (now_bin),
    .bcd_out          (now_bcd)
  );

  alarm_key_input #(
    .LONG_CYCLES (HOLD_CYCLES)
  ) u_key_up (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .key_raw_in (key_up_in),
    .press_out  (up_press),
    .short_out  (),
    .long_out   ()
  );

  alarm_key_input #(
    .LONG_CYCLES (HOLD_CYCLES)
  ) u_key_down (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .key_raw_in (key_down_in),
    .press_out  (down_press),
    .short_out  (),
    .long_out   ()
  );

  alarm_key_input #(
    .LONG_CYCLES (HOLD_CYCLES)
  ) u_key_shift (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .key_raw_in (key_shift_in),
    .press_out  (),
    .short_out  (shift_short),
    .long_out   (shift_long)
  );

  // newest logged entry with the same code decides; older ones are shadowed
  always @* begin
    hit     = 1'b0;
    hit_bin = {BIN_W{1'b0}};
    for (i = DEPTH - 1; i >= 0; i = i - 1) begin
      if (valid_ff[i] && (code_ff[i] == alarm_code_in)) begin
        hit     = 1'b1;
        hit_bin = bin_ff[i];
      end
    end
    elapsed = now_bin - hit_bin;
  end

  assign accept    = !hit || (elapsed > HOUR_UNITS);
  assign do_record = alarm_event_in && accept;

  // a clear and a recorded alarm in one cycle leave just that alarm; a repeat dropped against the old history leaves none
  assign nxt_valid = history_clear_function_in ?
                     {{(DEPTH-1){1'b0}}, do_record} :
                     do_record ? {valid_ff[DEPTH-2:0], 1'b1} : valid_ff;

  // history is only emptied by the clear function or power-up reset
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      valid_ff <= {DEPTH{1'b0}};
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  // newest slot takes the alarm and its stamp
  always @(posedge clk_sys_in) begin
    if (do_record) begin
      code_ff[0] <= alarm_code_in;
      bcd_ff[0]  <= now_bcd;
      bin_ff[0]  <= now_bin;
    end
  end

  // the oldest entry falls off the far end
  genvar g;
  generate
    for (g = 1; g < DEPTH; g = g + 1) begin : slot
      always @(posedge clk_sys_in) begin
        if (do_record) begin
          code_ff[g] <= code_ff[g-1];
          bcd_ff[g]  <= bcd_ff[g-1];
          bin_ff[g]  <= bin_ff[g-1];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      record_out  <= 1'b0;
      discard_out <= 1'b0;
    end else begin
      record_out  <= do_record;
      discard_out <= alarm_event_in && !accept;
    end
  end

  always @* begin
    nxt_count = {`AHR_IDX_W{1'b0}};
    for (j = 0; j < DEPTH; j = j + 1) begin
      if (valid_ff[j]) begin
        nxt_count = nxt_count + IDX_ONE;
      end
    end
  end

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      history_count_out <= {`AHR_IDX_W{1'b0}};
    end else begin
      history_count_out <= nxt_count;
    end
  end

  // view walker; entry needs the menu selection and a long shift press
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_ff         <= STATE_IDLE;
      index_ff         <= {`AHR_IDX_W{1'b0}};
      field_ff         <= `AHR_FLD_CODE;
      exit_to_menu_out <= 1'b0;
    end else begin
      exit_to_menu_out <= 1'b0;
      case (state_ff)
        STATE_IDLE: begin
          if (alarm_history_view_in && shift_long) begin
            state_ff <= STATE_VIEW;
            index_ff <= {`AHR_IDX_W{1'b0}};
            field_ff <= `AHR_FLD_CODE;
          end
        end
        STATE_VIEW: begin
          if (shift_long) begin
            state_ff         <= STATE_IDLE;
            exit_to_menu_out <= 1'b1;
          end else begin
            if (down_press && !up_press && index_ff != IDX_LAST) begin
              index_ff <= index_ff + IDX_ONE;
            end else if (up_press && !down_press &&
                         index_ff != {`AHR_IDX_W{1'b0}}) begin
              index_ff <= index_ff - IDX_ONE;
            end
            if (shift_short) begin
              field_ff <= field_ff + 2'h1;
            end
          end
        end
        default: begin
          state_ff <= STATE_IDLE;
        end
      endcase
    end
  end

  // digit group for the current field
  always @* begin
    sel_code  = code_ff[index_ff];
    sel_bcd   = bcd_ff[index_ff];
    sel_valid = valid_ff[index_ff];
    case (field_ff)
      `AHR_FLD_CODE: begin
        nxt_digits = {{(`AHR_GROUP_W-CODE_W){1'b0}}, sel_code};
      end
      `AHR_FLD_LOW: begin
        nxt_digits = sel_bcd[`AHR_LOW_LSB+:`AHR_GROUP_W];
      end
      `AHR_FLD_MID: begin
        nxt_digits = sel_bcd[`AHR_MID_LSB+:`AHR_GROUP_W];
      end
      `AHR_FLD_HIGH: begin
        nxt_digits = {{(`AHR_GROUP_W-`AHR_HIGH_W){1'b0}},
                      sel_bcd[`AHR_HIGH_LSB+:`AHR_HIGH_W]};
      end
      default: begin
        nxt_digits = {`AHR_GROUP_W{1'b0}};
      end
    endcase
    if (!sel_valid) begin
      nxt_digits = {`AHR_GROUP_W{1'b0}};
    end
  end

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      disp_active_out <= 1'b0;
      disp_index_out  <= {`AHR_IDX_W{1'b0}};
      disp_field_out  <= `AHR_FLD_CODE;
      disp_empty_out  <= 1'b0;
      disp_digits_out <= {`AHR_GROUP_W{1'b0}};
    end else begin
      disp_active_out <= (state_ff == STATE_VIEW);
      disp_index_out  <= index_ff;
      disp_field_out  <= field_ff;
      disp_empty_out  <= (state_ff == STATE_VIEW) && !sel_valid;
      disp_digits_out <= nxt_digits;
    end
  end

endmodule // alarm_history_recorder
`default_nettype wire

// file: hw/alarm_key_input.v
`timescale 1ns/100ps
`default_nettype none
// keypad key: pin synchroniser, press edge, short release and long hold
module alarm_key_input #(
  parameter LONG_CYCLES = 100000000
) (
  // clock and reset
  input  wire clk_sys_in,
  input  wire srst_in,
  // key pin
  input  wire key_raw_in,
  // events
  output reg  press_out,
  output reg  short_out,
  output reg  long_out
);

  localparam [31:0] LONG_LAST = LONG_CYCLES - 1;

  reg        sync1_ff;
  reg        sync2_ff;
  reg        sync3_ff;
  reg        level_ff;
  reg        long_done_ff;
  reg [31:0] hold_cnt_ff;

  always @(posedge clk_sys_in) begin
    sync1_ff <= key_raw_in;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
  end

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      level_ff     <= 1'b0;
      long_done_ff <= 1'b0;
      hold_cnt_ff  <= 32'h0000_0000;
      press_out    <= 1'b0;
      short_out    <= 1'b0;
      long_out     <= 1'b0;
    end else begin
      press_out <= 1'b0;
      short_out <= 1'b0;
      long_out  <= 1'b0;
      if (sync2_ff == sync3_ff) begin
        level_ff <= sync3_ff;
      end
      if (sync2_ff == sync3_ff && sync3_ff && !level_ff) begin
        press_out   <= 1'b1;
        hold_cnt_ff <= 32'h0000_0000;
      end else if (level_ff && sync3_ff && !long_done_ff) begin
        // one long event per hold, release then ends silently
        if (hold_cnt_ff == LONG_LAST) begin
          long_out     <= 1'b1;
          long_done_ff <= 1'b1;
        end else begin
          hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
        end
      end
      if (sync2_ff == sync3_ff && !sync3_ff && level_ff) begin
        short_out    <= !long_done_ff;
        long_done_ff <= 1'b0;
      end
    end
  end

endmodule // alarm_key_input
`default_nettype wire

// file: hw/operating_time_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "alarm_history_map.vh"
// power-on time accumulator, one count per tick, binary and decimal
module operating_time_counter #(
  parameter TICK_CYCLES = 10000000,
  parameter DIGITS      = 10,
  parameter BIN_W       = 32
) (
  // clock and reset
  input  wire               clk_sys_in,
  input  wire               srst_in,
  // power good pins
  input  wire               ctrl_power_on_in,
  input  wire               main_power_on_in,
  // running total
  output reg  [BIN_W-1:0]    bin_out,
  output wire [4*DIGITS-1:0] bcd_out
);

  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  reg  [1:0]    sync1_ff;
  reg  [1:0]    sync2_ff;
  reg  [1:0]    sync3_ff;
  reg  [1:0]    on_ff;
  reg  [31:0]   pre_ff;
  wire          tick;
  wire [DIGITS:0] carry;

  always @(posedge clk_sys_in) begin
    sync1_ff <= {main_power_on_in, ctrl_power_on_in};
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
  end

  // counts only while both supplies are up
  assign tick     = (pre_ff == TICK_LAST) && (&on_ff);
  assign carry[0] = tick;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      on_ff   <= 2'h0;
      pre_ff  <= 32'h0000_0000;
      bin_out <= {BIN_W{1'b0}};
    end else begin
      on_ff <= (sync2_ff & sync3_ff) | (on_ff & (sync2_ff | sync3_ff));
      if (!(&on_ff) || tick) begin
        pre_ff <= 32'h0000_0000;
      end else begin
        pre_ff <= pre_ff + 32'h0000_0001;
      end
      if (tick) begin
        bin_out <= bin_out + {{(BIN_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ten decimal digits hold about 31 years of 100 ms counts
  genvar g;
  generate
    for (g = 0; g < DIGITS; g = g + 1) begin : digit
      reg [3:0] dig_ff;
      assign carry[g+1]      = carry[g] && (dig_ff == `AHR_BCD_NINE);
      assign bcd_out[4*g+:4] = dig_ff;
      always @(posedge clk_sys_in) begin
        if (srst_in) begin
          dig_ff <= `AHR_BCD_ZERO;
        end else if (carry[g]) begin
          dig_ff <= (dig_ff == `AHR_BCD_NINE) ? `AHR_BCD_ZERO :
                    dig_ff + 4'h1;
        end
      end
    end
  endgenerate

endmodule // operating_time_counter
`default_nettype wire

// file: test/alarm_history_recorder_properties.sv
`timescale 1ns/100ps
`default_nettype none
module alarm_history_recorder_properties #(
  parameter DEPTH  = 10,
  parameter CODE_W = 12
) (
  // clock, reset, supplies, alarms
  input wire logic              clk_sys_in,
  input wire logic              srst_in,
  input wire logic              ctrl_power_on_in,
  input wire logic              main_power_on_in,
  input wire logic              alarm_event_in,
  input wire logic [CODE_W-1:0] alarm_code_in,
  input wire logic              history_clear_function_in,
  // keys and menu
  input wire logic              key_up_in,
  input wire logic              key_down_in,
  input wire logic              key_shift_in,
  input wire logic              alarm_history_view_in,
  // display and status
  input wire logic              disp_active_out,
  input wire logic [3:0]        disp_index_out,
  input wire logic [1:0]        disp_field_out,
  input wire logic              disp_empty_out,
  input wire logic [15:0]       disp_digits_out,
  input wire logic              exit_to_menu_out,
  input wire logic              record_out,
  input wire logic              discard_out,
  input wire logic [3:0]        history_count_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  chk_alarm_answer: assert property (
    alarm_event_in |=> record_out ^ discard_out)
    else $error("alarm not answered");
  chk_answer_cause: assert property (
    record_out || discard_out |-> $past(alarm_event_in))
    else $error("answer without alarm");
  chk_count_limit: assert property (
    history_count_out <= DEPTH)
    else $error("count above depth");
  chk_count_step: assert property (
    record_out && !$past(history_clear_function_in)
      && history_count_out < DEPTH
      |=> history_count_out == $past(history_count_out) + 4'h1)
    else $error("count not stepped");
  chk_clear_count: assert property (
    history_clear_function_in && !alarm_event_in
      |-> ##2 history_count_out == 4'h0)
    else $error("clear did not empty");
  chk_exit_view: assert property (
    exit_to_menu_out |-> $past(disp_active_out) ##[0:1] !disp_active_out)
    else $error("exit without leaving view");
  chk_exit_pulse: assert property (
    exit_to_menu_out |=> !exit_to_menu_out)
    else $error("exit pulse too long");
  chk_index_step: assert property (
    disp_active_out && $past(disp_active_out)
      |-> disp_index_out - $past(disp_index_out) + 4'h1 <= 4'h2)
    else $error("index jumped");
  chk_field_order: assert property (
    disp_active_out && $past(disp_active_out)
      && disp_field_out != $past(disp_field_out)
      |-> disp_field_out == $past(disp_field_out) + 2'h1)
    else $error("field out of order");
  chk_empty_blank: assert property (
    disp_active_out && disp_empty_out |-> disp_digits_out == 16'h0000)
    else $error("empty slot not blank");

  cov_record: cover property (record_out);
  cov_discard: cover property (discard_out);
  cov_exit: cover property (exit_to_menu_out);
  cov_empty: cover property (disp_active_out && disp_empty_out);
endmodule // alarm_history_recorder_properties
`default_nettype wire

// file: test/keypad_model.sv
`timescale 1ns/100ps
`default_nettype none
// holds one key for the asked cycles, then keeps a quiet gap
module keypad_model (
  // clock
  input  wire logic       clk_sys_in,
  // request
  input  wire logic       req_in,
  input  wire logic [1:0] sel_in,
  input  wire logic [4:0] hold_in,
  // keys, high while pressed
  output wire logic       key_up_out,
  output wire logic       key_down_out,
  output wire logic       key_shift_out,
  output wire logic       busy_out
);
  logic [5:0] cnt_ff = 6'h00;
  logic [1:0] sel_ff = 2'h0;
  wire  logic press = cnt_ff > 6'h0c;
  always @(posedge clk_sys_in) begin
    if (req_in && cnt_ff == 6'h00) begin
      cnt_ff <= {1'b0, hold_in} + 6'h0c;
      sel_ff <= sel_in;
    end else if (cnt_ff != 6'h00) begin
      cnt_ff <= cnt_ff - 6'h01;
    end
  end
  assign key_up_out    = press && sel_ff == 2'h0;
  assign key_down_out  = press && sel_ff == 2'h1;
  assign key_shift_out = press && sel_ff == 2'h2;
  assign busy_out      = cnt_ff != 6'h00;
endmodule // keypad_model
`default_nettype wire

// file: test/test_alarm_history_recorder.sv
`timescale 1ns/100ps
`default_nettype none
module test_alarm_history_recorder;
  logic        clk = 1'b0, srst = 1'b1, pc = 1'b1, pm = 1'b1;
  logic        ev = 1'b0, clr = 1'b0, view = 1'b0, req = 1'b0;
  logic [11:0] code = 12'h000;
  logic [1:0]  sel = 2'h0;
  logic [4:0]  hold = 5'h00;
  wire  logic  ku, kd, ks, busy, act, emp, ext, rec, dsc;
  wire  logic [3:0]  idx, cnt;
  wire  logic [1:0]  fld;
  wire  logic [15:0] dig;
  int          mismatches = 0, checked = 0, i, s0, s1, exits = 0;
  // key, index, field
  logic [7:0]  rows [9] = '{8'hc0, 8'h00, 8'h44, 8'h48, 8'h89, 8'h8a,
                            8'h8b, 8'h88, 8'h04};

  alarm_history_recorder #(.TICK_CYCLES(2), .HOLD_CYCLES(8)) uut (
    .clk_sys_in(clk), .srst_in(srst),
    .ctrl_power_on_in(pc), .main_power_on_in(pm),
    .alarm_event_in(ev), .alarm_code_in(code),
    .history_clear_function_in(clr),
    .key_up_in(ku), .key_down_in(kd), .key_shift_in(ks),
    .alarm_history_view_in(view),
    .disp_active_out(act), .disp_index_out(idx), .disp_field_out(fld),
    .disp_empty_out(emp), .disp_digits_out(dig),
    .exit_to_menu_out(ext), .record_out(rec), .discard_out(dsc),
    .history_count_out(cnt));

  keypad_model partner (.clk_sys_in(clk), .req_in(req), .sel_in(sel),
    .hold_in(hold), .key_up_out(ku), .key_down_out(kd),
    .key_shift_out(ks), .busy_out(busy));

  initial forever #5 clk = ~clk;

  // counts exit pulses while they stand
  always @(posedge clk) if (ext === 1'b1) exits <= exits + 1;

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic ck(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t check mismatch", $time);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // 0 up, 1 down, 2 short shift, 3 long shift
  task automatic key(input logic [1:0] k);
    int n;
    @(posedge clk);
    req <= 1'b1;
    sel <= k[1] ? 2'h2 : k;
    hold <= (k == 2'h3) ? 5'h0e : 5'h03;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (busy && n < 100);
    if (busy) begin
      ck(1'b0);
      wrap_up();
    end
  endtask

  task automatic fire(input logic [11:0] c, input logic cl,
                      input logic r);
    @(posedge clk);
    ev <= 1'b1;
    code <= c;
    clr <= cl;
    @(posedge clk);
    ev <= 1'b0;
    clr <= 1'b0;
    #1;
    ck(rec === r && dsc === !r);
  endtask

  function automatic int dec4(input logic [15:0] d);
    return d[15:12] * 1000 + d[11:8] * 100 + d[7:4] * 10 + d[3:0];
  endfunction

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
    ck(rec === 1'b0 && act === 1'b0 && cnt === 4'h0);
    ck(2.0 ** $bits(uut.now_bin) > 13.0 * 365.25 * 864000.0);
    for (i = 1; i < 12; i++)
      fire(12'(i), 1'b0, 1'b1);
    tick(2);
    ck(cnt === 4'ha);
    @(posedge clk);
    view <= 1'b1;
    for (i = 0; i < 9; i++) begin
      key(rows[i][7:6]);
      ck(act === 1'b1 && idx === rows[i][5:2]);
      ck(fld === rows[i][1:0]);
      if (rows[i][1:0] == 2'h0)
        ck(dig === {12'h000, 4'hb - rows[i][5:2]});
    end
    for (i = 0; i < 9; i++)
      key(2'h1);
    ck(idx === 4'h9 && dig === 16'h0002);
    key(2'h3);
    ck(act === 1'b0);
    @(posedge clk);
    pm <= 1'b0;
    key(2'h3);
    ck(act === 1'b1 && dig === 16'h000b);
    key(2'h3);
    ck(cnt === 4'ha);
    @(posedge clk);
    pm <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(1);
    ck(cnt === 4'h0);
    key(2'h3);
    ck(emp === 1'b1 && idx === 4'h0 && dig === 16'h0000);
    key(2'h1);
    ck(emp === 1'b1 && idx === 4'h1);
    key(2'h3);
    fire(12'h005, 1'b1, 1'b1);
    fire(12'h005, 1'b0, 1'b0);
    fire(12'h006, 1'b0, 1'b1);
    tick(71992);
    fire(12'h005, 1'b0, 1'b0);
    fire(12'h005, 1'b0, 1'b0);
    fire(12'h005, 1'b0, 1'b1);
    key(2'h3);
    key(2'h2);
    s0 = dec4(dig);
    key(2'h1);
    s1 = dec4(dig);
    key(2'h2);
    s1 = s1 + 10000 * dec4(dig);
    key(2'h0);
    s0 = s0 + 10000 * dec4(dig);
    ck(s0 - s1 == 35999);
    key(2'h3);
    fire(12'h007, 1'b0, 1'b1);
    @(posedge clk);
    pc <= 1'b0;
    tick(200);
    @(posedge clk);
    pc <= 1'b1;
    fire(12'h008, 1'b0, 1'b1);
    key(2'h3);
    key(2'h2);
    s0 = dec4(dig);
    key(2'h1);
    s1 = dec4(dig);
    // control supply off: stamps must stay close together
    ck((s0 - s1 + 10000) % 10000 < 8);
    ck(exits == 4);
    @(posedge clk);
    srst <= 1'b1;
    tick(5);
    @(posedge clk);
    srst <= 1'b0;
    #1;
    ck(act === 1'b0 && cnt === 4'h0 && rec === 1'b0);
    wrap_up();
  end
endmodule // test_alarm_history_recorder

bind alarm_history_recorder alarm_history_recorder_properties #(
  .DEPTH(DEPTH), .CODE_W(CODE_W)) chk (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in),
  .ctrl_power_on_in(ctrl_power_on_in),
  .main_power_on_in(main_power_on_in),
  .alarm_event_in(alarm_event_in), .alarm_code_in(alarm_code_in),
  .history_clear_function_in(history_clear_function_in),
  .key_up_in(key_up_in), .key_down_in(key_down_in),
  .key_shift_in(key_shift_in),
  .alarm_history_view_in(alarm_history_view_in),
  .disp_active_out(disp_active_out), .disp_index_out(disp_index_out),
  .disp_field_out(disp_field_out), .disp_empty_out(disp_empty_out),
  .disp_digits_out(disp_digits_out),
  .exit_to_menu_out(exit_to_menu_out), .record_out(record_out),
  .discard_out(discard_out), .history_count_out(history_count_out));
`default_nettype wire
